// File: rtl/sadc_params.svh
/*
  Constants of the converter sequencer: register offsets, field positions,
  reset values and conversion timing.
  Assumes it is included by bare name from the package and the testbench.
*/
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH

`define SADC_ADDR_W       5
`define SADC_OFS_CTRL_A   5'h00
`define SADC_OFS_CTRL_B   5'h04
`define SADC_OFS_SEL      5'h08
`define SADC_OFS_RES_LO   5'h0C
`define SADC_OFS_RES_HI   5'h10

`define SADC_CA_ENABLE    7
`define SADC_CA_START     6
`define SADC_CA_AUTO      5
`define SADC_CA_FLAG      4
`define SADC_SEL_LEFT     5

`define SADC_RST_PSEL     3'h0
`define SADC_RST_TSRC     3'h0
`define SADC_TSRC_FREE    3'h0

`define SADC_RESP_OKAY    2'b00
`define SADC_RESP_SLVERR  2'b10

// timing in half periods of the divided converter clock; trigger sync in cpu cycles
`define SADC_NORM_END     6'd26
`define SADC_NORM_SH      6'd3
`define SADC_FIRST_END    6'd50
`define SADC_FIRST_SH     6'd27
`define SADC_AUTO_END     6'd27
`define SADC_AUTO_SH      6'd4
`define SADC_LAST_WINDOW  6'd2
`define SADC_TRIG_SYNC    3

`endif

// File: rtl/sadc_pkg.sv
/*
  Types, register decode and timing functions of the converter sequencer.
  Assumes sadc_params.svh is on the include path.
*/
`include "sadc_params.svh"

package sadc_pkg;

  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_CONV = 1'b1} sadc_conv_st_t;

  typedef enum logic [1:0] {
    KIND_NORMAL = 2'b00,
    KIND_FIRST  = 2'b01,
    KIND_AUTO   = 2'b10
  } sadc_kind_t;

  typedef enum logic [2:0] {
    REG_CTRL_A = 3'b000,
    REG_CTRL_B = 3'b001,
    REG_SEL    = 3'b010,
    REG_RES_LO = 3'b011,
    REG_RES_HI = 3'b100,
    REG_NONE   = 3'b111
  } sadc_reg_t;

  typedef struct packed {
    logic [1:0] reference_select;
    logic [3:0] channel_select;
  } sadc_sel_t;

  typedef struct packed {
    logic      enable;
    logic      converting;
    logic      sample_hold;
    logic      done_pulse;
    sadc_sel_t sel;
  } sadc_ana_t;

  typedef struct packed {
    logic [6:0] cnt;
  } sadc_presc_t;

  function automatic sadc_reg_t sadc_decode(input logic [`SADC_ADDR_W-1:0] a);
    case (a)
      `SADC_OFS_CTRL_A: sadc_decode = REG_CTRL_A;
      `SADC_OFS_CTRL_B: sadc_decode = REG_CTRL_B;
      `SADC_OFS_SEL:    sadc_decode = REG_SEL;
      `SADC_OFS_RES_LO: sadc_decode = REG_RES_LO;
      `SADC_OFS_RES_HI: sadc_decode = REG_RES_HI;
      default:          sadc_decode = REG_NONE;
    endcase
  endfunction

  function automatic logic [5:0] sadc_conv_end(input sadc_kind_t k);
    case (k)
      KIND_FIRST: sadc_conv_end = `SADC_FIRST_END;
      KIND_AUTO:  sadc_conv_end = `SADC_AUTO_END;
      default:    sadc_conv_end = `SADC_NORM_END;
    endcase
  endfunction

  function automatic logic [5:0] sadc_conv_sh(input sadc_kind_t k);
    case (k)
      KIND_FIRST: sadc_conv_sh = `SADC_FIRST_SH;
      KIND_AUTO:  sadc_conv_sh = `SADC_AUTO_SH;
      default:    sadc_conv_sh = `SADC_NORM_SH;
    endcase
  endfunction

endpackage

// File: rtl/sadc_prescaler.sv
/*
  Converter clock prescaler: power-of-two divider of the cpu clock giving
  rising and falling tick pulses of the divided converter clock.
  Assumes enable and restart are synchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module sadc_prescaler
  import sadc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       enable,
  input  wire logic       restart,
  input  wire logic [2:0] prescaler_select,
  output logic            rise_tick,
  output logic            fall_tick,
  output logic [6:0]      count
);

  sadc_presc_t q;
  sadc_presc_t d;
  logic [6:0]  last;

  // select codes 0 and 1 both divide by two
  always_comb begin
    case (prescaler_select)
      3'h0, 3'h1: last = 7'h01;
      3'h2:       last = 7'h03;
      3'h3:       last = 7'h07;
      3'h4:       last = 7'h0F;
      3'h5:       last = 7'h1F;
      3'h6:       last = 7'h3F;
      default:    last = 7'h7F;
    endcase
    d = q;
    if (!enable || restart) begin
      d.cnt = 7'h00;
    end else if (q.cnt >= last) begin
      d.cnt = 7'h00;
    end else begin
      d.cnt = q.cnt + 7'h01;
    end
    rise_tick = enable && !restart && (q.cnt == last);
    fall_tick = enable && !restart && (q.cnt == (last >> 1));
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '{cnt: 7'h00};
    end else begin
      q <= d;
    end
  end

  assign count = q.cnt;

endmodule

`default_nettype wire

// File: rtl/sadc_top.sv
/*
  Conversion sequencer of a 10-bit successive-approximation converter with
  an AXI4-Lite register slave, auto trigger, free running and result lock.
  Assumes trigger levels and the sar result are synchronous to ref_clk and
  that the result is valid in the last converting cycle, before done_pulse is raised.
*/
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
// Operation
// - result shown right-justified, left-justified when the justify bit is set
// - reading the low byte locks both bytes; completions while locked are dropped
// - reading the high byte releases the lock
// - done flag still sets when the result was dropped
// - start bit begins a conversion, stays set while converting, self-clears
// - channel change mid-conversion waits until the last converter cycle of that conversion
// - auto mode trigger rising edge resets prescaler and starts conversion
// - trigger still high at end starts no new conversion
// - trigger edges during a conversion are ignored, not queued
// - own done flag as source restarts after each end; first via start bit
// - start bit works in auto mode and reads one during any conversion
// - prescaler counts only while enabled, held in reset otherwise
// - start bit conversion begins on next rising converter clock edge
// - normal conversion 13 converter cycles, first after enable 25; a trigger-started first conversion takes the auto 13.5
// - sample-hold 1.5 cycles into normal, 13.5 into first conversion
// - completion writes result, sets flag, clears start bit in single mode
// - auto conversion samples 2 cycles after trigger, lasts 13.5 cycles
// - trigger events pass three cpu cycles of synchronisation first
// - free running starts next conversion at completion, start bit stays one
// - channel and reference take effect only while converter is enabled
// - selection frozen once a conversion starts
// - selection copying resumes in the last converter cycle of a conversion
`timescale 1ns/1ps
`default_nettype none

module sadc_top
  import sadc_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    nrst,
  input  wire logic [`SADC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`SADC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic [6:0]              trig_src,
  input  wire logic [9:0]              sar_result,
  output sadc_ana_t                    ana
);

  typedef struct packed {
    logic                    enable;
    logic                    start_bit;
    logic                    auto_en;
    logic                    done_flag;
    logic [2:0]              psel;
    logic [2:0]              tsrc;
    sadc_sel_t               sel_buf;
    logic                    left_just;
    sadc_sel_t               sel_live;
    logic [9:0]              result;
    logic                    lock;
    sadc_conv_st_t           cst;
    sadc_kind_t              kind;
    logic [5:0]              halves;
    logic                    first;
    logic                    trig_prev;
    logic [`SADC_TRIG_SYNC-1:0] trig_pipe;
    logic                    sample_hold;
    logic                    done_pulse;
    logic                    awready;
    logic                    wready;
    logic                    aw_full;
    logic                    w_full;
    logic [`SADC_ADDR_W-1:0] awaddr;
    logic [7:0]              wdata;
    logic                    wstb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [1:0]              rresp;
    logic [7:0]              rdata;
  } sadc_state_t;

  sadc_state_t q;
  sadc_state_t d;
  logic        rise_tick;
  logic        fall_tick;
  logic [6:0]  presc_cnt;
  logic        tick;
  logic        completing;
  logic        free_run;
  logic        act;
  logic        trig_level;
  logic        trig_edge;
  logic        flag_clr;
  logic        start_wr;
  logic        rd_hi;
  sadc_reg_t   widx;
  sadc_reg_t   ridx;
  logic [15:0] fmt;

  // a trigger may only act when idle; edges seen while busy are dropped here
  assign act = q.trig_pipe[`SADC_TRIG_SYNC-1] && q.enable && q.auto_en &&
               (q.tsrc != `SADC_TSRC_FREE) && (q.cst == ST_IDLE);

  sadc_prescaler u_presc (
    .ref_clk          (ref_clk),
    .nrst             (nrst),
    .enable           (q.enable),
    .restart          (act),
    .prescaler_select (q.psel),
    .rise_tick        (rise_tick),
    .fall_tick        (fall_tick),
    .count            (presc_cnt)
  );

  always_comb begin
    d             = q;
    d.sample_hold = 1'b0;
    d.done_pulse  = 1'b0;
    flag_clr      = 1'b0;
    start_wr      = 1'b0;
    rd_hi         = 1'b0;
    widx          = sadc_decode(q.awaddr);
    ridx          = sadc_decode(s_axi_araddr);
    tick          = rise_tick | fall_tick;
    free_run      = q.auto_en && (q.tsrc == `SADC_TSRC_FREE);
    trig_level    = (q.tsrc == `SADC_TSRC_FREE) ? 1'b0 : trig_src[q.tsrc - 3'h1];
    trig_edge     = trig_level && !q.trig_prev;
    completing    = (q.cst == ST_CONV) && tick &&
                    ((q.halves + 6'd1) == sadc_conv_end(q.kind));
    // alignment applied at read time, so the justify bit acts at once
    if (q.left_just) begin
      fmt = {q.result, 6'h00};
    end else begin
      fmt = {6'h00, q.result};
    end

    // write address and data may arrive in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_full = 1'b1;
      d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_full = 1'b1;
      d.wdata  = s_axi_wdata[7:0];
      d.wstb   = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_full && q.w_full && !q.bvalid) begin
      d.aw_full = 1'b0;
      d.w_full  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = (widx == REG_NONE) ? `SADC_RESP_SLVERR : `SADC_RESP_OKAY;
      if (q.wstb) begin
        case (widx)
          REG_CTRL_A: begin
            d.enable  = q.wdata[`SADC_CA_ENABLE];
            d.auto_en = q.wdata[`SADC_CA_AUTO];
            d.psel    = q.wdata[2:0];
            start_wr  = q.wdata[`SADC_CA_START];
            flag_clr  = q.wdata[`SADC_CA_FLAG];
          end
          REG_CTRL_B: d.tsrc = q.wdata[2:0];
          REG_SEL: begin
            d.sel_buf   = q.wdata[`SADC_SEL_LEFT-1] ? q.sel_buf : q.sel_buf;
            d.sel_buf   = {q.wdata[7:6], q.wdata[3:0]};
            d.left_just = q.wdata[`SADC_SEL_LEFT];
          end
          default: d.bresp = d.bresp;
        endcase
      end
    end
    d.awready = !d.aw_full && !d.bvalid;
    d.wready  = !d.w_full && !d.bvalid;

    // one read at a time; arready drops until the answer is taken
    if (q.rvalid && s_axi_rready) begin
      d.rvalid  = 1'b0;
      d.arready = 1'b1;
    end
    if (s_axi_arvalid && q.arready) begin
      d.arready = 1'b0;
      d.rvalid  = 1'b1;
      d.rresp   = (ridx == REG_NONE) ? `SADC_RESP_SLVERR : `SADC_RESP_OKAY;
      case (ridx)
        REG_CTRL_A: d.rdata = {q.enable, q.start_bit, q.auto_en, q.done_flag, 1'b0, q.psel};
        REG_CTRL_B: d.rdata = {5'h00, q.tsrc};
        REG_SEL:    d.rdata = {q.sel_buf.reference_select, q.left_just, 1'b0,
                               q.sel_buf.channel_select};
        REG_RES_LO: begin
          d.rdata = fmt[7:0];
          d.lock  = 1'b1;
        end
        REG_RES_HI: begin
          d.rdata = fmt[15:8];
          d.lock  = 1'b0;
          rd_hi   = 1'b1;
        end
        default:    d.rdata = 8'h00;
      endcase
    end

    // software clear is applied first so a hardware set in the same cycle wins
    if (flag_clr) begin
      d.done_flag = 1'b0;
    end

    // edge is delayed through the pipe before it may act
    d.trig_prev = trig_level;
    d.trig_pipe = {q.trig_pipe[`SADC_TRIG_SYNC-2:0], trig_edge};

    if ((q.cst == ST_CONV) && tick) begin
      d.halves = q.halves + 6'd1;
      if ((q.halves + 6'd1) == sadc_conv_sh(q.kind)) begin
        d.sample_hold = 1'b1;
      end
    end
    if (completing) begin
      d.cst        = ST_IDLE;
      d.done_pulse = 1'b1;
      d.done_flag  = 1'b1;
      d.start_bit  = 1'b0;
      if (!q.lock) begin
        d.result = sar_result;
      end
      if (free_run) begin
        d.cst       = ST_CONV;
        d.kind      = KIND_NORMAL;
        d.halves    = 6'd0;
        d.start_bit = 1'b1;
      end
    end else if (act) begin
      d.cst       = ST_CONV;
      d.kind      = KIND_AUTO;
      d.halves    = 6'd0;
      d.start_bit = 1'b1;
      d.first     = 1'b0;
    end else if ((q.cst == ST_IDLE) && q.start_bit && rise_tick) begin
      d.cst    = ST_CONV;
      d.kind   = q.first ? KIND_FIRST : KIND_NORMAL;
      d.halves = 6'd0;
      d.first  = 1'b0;
    end
    if (start_wr) begin
      d.start_bit = 1'b1;
    end

    // selection passes to the analog side only when idle or in the last cycle
    if (q.enable && ((q.cst == ST_IDLE) ||
        (q.halves >= (sadc_conv_end(q.kind) - `SADC_LAST_WINDOW)))) begin
      d.sel_live = q.sel_buf;
    end

    // disabling aborts any conversion and rearms the long first conversion
    if (!d.enable) begin
      d.cst         = ST_IDLE;
      d.sample_hold = 1'b0;
      d.start_bit   = 1'b0;
      d.halves    = 6'd0;
      d.first     = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '{cst: ST_IDLE, kind: KIND_NORMAL, psel: `SADC_RST_PSEL, tsrc: `SADC_RST_TSRC,
             awready: 1'b1, wready: 1'b1, arready: 1'b1, first: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready   = q.awready;
  assign s_axi_wready    = q.wready;
  assign s_axi_bvalid    = q.bvalid;
  assign s_axi_bresp     = q.bresp;
  assign s_axi_arready   = q.arready;
  assign s_axi_rvalid    = q.rvalid;
  assign s_axi_rresp     = q.rresp;
  assign s_axi_rdata     = {24'h000000, q.rdata};
  // one driver for the whole packed bundle
  assign ana = {q.enable, (q.cst == ST_CONV), q.sample_hold, q.done_pulse, q.sel_live};

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_quiet;
    q.enable && q.auto_en && (q.cst == ST_IDLE) && !q.start_bit &&
      (q.tsrc != `SADC_TSRC_FREE);
  endsequence

  sequence s_trig_seen;
    trig_edge ##0 s_quiet;
  endsequence

  property p_busy_start;
    (q.cst == ST_CONV) |-> q.start_bit;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("start bit low while converting");

  property p_lock_hold;
    (q.lock && completing) |=> $stable(q.result);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked result was overwritten");

  property p_unlock;
    rd_hi |=> !q.lock;
  endproperty
  a_unlock: assert property (p_unlock) else $error("high byte read left lock set");

  property p_flag_on_done;
    completing |=> q.done_flag && q.done_pulse;
  endproperty
  a_flag_on_done: assert property (p_flag_on_done) else $error("done flag not set");

  property p_single_clear;
    (completing && !free_run && !start_wr && d.enable) |=> !q.start_bit && (q.cst == ST_IDLE);
  endproperty
  a_single_clear: assert property (p_single_clear) else $error("single conversion went on");

  property p_presc_reset;
    !q.enable |=> (presc_cnt == 7'h00);
  endproperty
  a_presc_reset: assert property (p_presc_reset) else $error("prescaler ran while disabled");

  property p_start_on_rise;
    ((q.cst == ST_IDLE) && !act) ##1 (q.cst == ST_CONV) |-> $past(rise_tick);
  endproperty
  a_start_on_rise: assert property (p_start_on_rise) else $error("start off a rising edge");

  property p_trig_sync;
    s_trig_seen ##1 s_quiet [*3] |=> (q.cst == ST_CONV) && (q.kind == KIND_AUTO) &&
                                     (q.halves == 6'd0) && (presc_cnt == 7'h00);
  endproperty
  a_trig_sync: assert property (p_trig_sync) else $error("trigger not acted on after sync");

  property p_trig_not_early;
    s_trig_seen ##1 s_quiet |=> (q.cst == ST_IDLE);
  endproperty
  a_trig_not_early: assert property (p_trig_not_early) else $error("trigger acted too early");

  property p_trig_ignored;
    (q.trig_pipe[`SADC_TRIG_SYNC-1] && (q.cst == ST_CONV) && !completing && d.enable) |=>
      (q.cst == ST_CONV) && $stable(q.kind) && (q.halves >= $past(q.halves));
  endproperty
  a_trig_ignored: assert property (p_trig_ignored) else $error("busy trigger restarted");

  property p_sh_point;
    q.sample_hold |-> (q.halves == sadc_conv_sh(q.kind)) && (q.cst == ST_CONV);
  endproperty
  a_sh_point: assert property (p_sh_point) else $error("sample-hold at wrong point");

  property p_length;
    q.done_pulse |-> ($past(q.halves) == (sadc_conv_end($past(q.kind)) - 6'd1));
  endproperty
  a_length: assert property (p_length) else $error("conversion length wrong");

  property p_sel_frozen;
    ((q.cst == ST_CONV) && (q.halves < (sadc_conv_end(q.kind) - `SADC_LAST_WINDOW)))
      ##1 (q.cst == ST_CONV) |-> $stable(q.sel_live);
  endproperty
  a_sel_frozen: assert property (p_sel_frozen) else $error("selection moved mid conversion");

  property p_free_run;
    (completing && free_run && d.enable) |=> (q.cst == ST_CONV) && q.start_bit &&
                                             (q.halves == 6'd0);
  endproperty
  a_free_run: assert property (p_free_run) else $error("free running did not restart");

  property p_no_level_retrig;
    (completing && !free_run && q.auto_en && !start_wr) |=> (q.cst == ST_IDLE);
  endproperty
  a_no_level_retrig: assert property (p_no_level_retrig) else $error("level retriggered");

endmodule

`default_nettype wire

// File: testbench/sadc_top_tb.sv
/*
  Self-checking bench of the converter sequencer: axi4-lite master tasks,
  an integer model of the result bytes and lock, trigger and timing scenarios.
  Assumes sadc_pkg and sadc_top are compiled before this file.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sadc_params.svh"

module sadc_top_tb;
  import sadc_pkg::*;
  logic        ref_clk, nrst, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
  logic [4:0]  awa, ara;
  logic [31:0] wd, rd, d;
  logic [3:0]  ws;
  logic [1:0]  bresp, rresp, r;
  logic [6:0]  trig;
  logic [9:0]  sar;
  sadc_ana_t   ana;
  int          n_fail, samples_checked, cyc, conv_cnt, done_cnt;
  int          res, old, nf, nn, d0, t1;

  sadc_top uut (.ref_clk(ref_clk), .nrst(nrst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .trig_src(trig),
    .sar_result(sar), .ana(ana));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic end_of_test();
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // cycle counter doubles as the hang limit
  always @(posedge ref_clk) begin
    cyc++;
    if (ana.converting === 1'b1) conv_cnt++;
    if (ana.done_pulse === 1'b1) done_cnt++;
    if (cyc == 30000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wreg(input logic [4:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    awa <= a; wd <= {24'h000000, v}; ws <= 4'hF; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (bv !== 1'b1);
    r = bresp;
    br <= 1'b0;
  endtask

  task automatic rreg(input logic [4:0] a);
    @(posedge ref_clk);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rd; r = rresp;
    rr <= 1'b0;
  endtask

  task automatic wait_done(input int n0);
    for (int i = 0; i < 3000 && done_cnt == n0; i++) @(posedge ref_clk);
  endtask

  task automatic conv(input logic [7:0] c);
    conv_cnt = 0;
    d0 = done_cnt;
    wreg(`SADC_OFS_CTRL_A, c);
    wait_done(d0);
  endtask

  // model formatting of the stored result
  function automatic logic [31:0] lo_of(input int v, input bit left);
    return left ? {24'h0, v[1:0], 6'h00} : {24'h0, v[7:0]};
  endfunction
  function automatic logic [31:0] hi_of(input int v, input bit left);
    return left ? {24'h0, v[9:2]} : {30'h0, v[9:8]};
  endfunction

  initial begin
    {awv, wv, br, arv, rr, nrst} = '0;
    {awa, ara, wd, ws, trig, sar} = '0;
    void'($urandom(82));
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    rreg(`SADC_OFS_CTRL_A);
    chk(d, 32'h0);
    rreg(5'h14);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, `SADC_RESP_SLVERR});
    wreg(5'h1C, 8'hFF);
    chk(r, `SADC_RESP_SLVERR);
    wreg(`SADC_OFS_SEL, 8'h43);
    chk(ana.sel, 6'h00);
    $display("test reset done");
    for (int p = 1; p <= 2; p++) begin
      wreg(`SADC_OFS_CTRL_A, 8'h00);
      sar <= 10'($urandom);
      trig <= 7'($urandom) & 7'h7E;
      conv(8'hC0 | p);
      nf = conv_cnt;
      res = sar;
      chk(ana.sel, 6'h13);
      rreg(`SADC_OFS_CTRL_A);
      chk(d, 32'h90 | p);
      wreg(`SADC_OFS_CTRL_A, 8'h90 | p);
      conv(8'hC0 | p);
      nn = conv_cnt;
      chk(nf - nn, 24 << (p - 1));
    end
    rreg(`SADC_OFS_RES_LO);
    chk(d, lo_of(res, 0));
    rreg(`SADC_OFS_RES_HI);
    chk(d, hi_of(res, 0));
    wreg(`SADC_OFS_SEL, 8'h63);
    rreg(`SADC_OFS_RES_LO);
    chk(d, lo_of(res, 1));
    $display("test timing and justify done");
    old = res;
    sar <= 10'($urandom);
    d0 = done_cnt;
    wreg(`SADC_OFS_CTRL_A, 8'hD1);
    wreg(`SADC_OFS_SEL, 8'h25);
    chk(ana.sel, 6'h13);
    wait_done(d0);
    repeat (2) @(posedge ref_clk);
    chk(ana.sel, 6'h05);
    rreg(`SADC_OFS_CTRL_A);
    chk(d[4], 1'b1);
    rreg(`SADC_OFS_RES_HI);
    chk(d, hi_of(old, 1));
    res = sar;
    conv(8'hD1);
    rreg(`SADC_OFS_RES_LO);
    chk(d, lo_of(res, 1));
    rreg(`SADC_OFS_RES_HI);
    chk(d, hi_of(res, 1));
    $display("test lock done");
    wreg(`SADC_OFS_CTRL_B, 8'h01);
    wreg(`SADC_OFS_CTRL_A, 8'hB1);
    d0 = done_cnt;
    trig[0] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rreg(`SADC_OFS_CTRL_A);
    chk(d[6], 1'b1);
    trig[0] <= 1'b0;
    repeat (2) @(posedge ref_clk);
    trig[0] <= 1'b1;
    wait_done(d0);
    repeat (100) @(posedge ref_clk);
    chk(done_cnt - d0, 1);
    $display("test auto trigger done");
    wreg(`SADC_OFS_CTRL_B, 8'h00);
    d0 = done_cnt;
    wreg(`SADC_OFS_CTRL_A, 8'hF1);
    wait_done(d0);
    t1 = cyc;
    wait_done(d0 + 1);
    chk(cyc - t1, 13 * 2);
    rreg(`SADC_OFS_CTRL_A);
    chk(d[6], 1'b1);
    wreg(`SADC_OFS_CTRL_A, 8'h00);
    $display("test free running done");
    end_of_test();
  end
endmodule
`default_nettype wire
